// >>> logic/pibf_bank.sv
/*
 * peripheral interrupt enable and flag bank with the masked request to the
 * core. assumes single-cycle event pulses from timers, converter and
 * comparators, level pending states from the serial and pulse units, and a
 * register port whose read data appear the cycle after the read strobe.
 */
// Design decisions made here: the address map and strobed register access.
// Overview of operation
// - first enable: gate, converter, rx, tx, two unused, period match, overflow.
// - second enable: comparator two in bit 6, comparator one in bit 5.
// - third enable: pulse units four..one in bits 7..4, low nibble unused.
// - first request mirrors first enable layout, bits 3 and 2 unused.
// - second request: comparator two flag bit 6, comparator one bit 5.
// - a flag at one means pending, zero means not pending.
// - source events set flags regardless of any enable bit.
// - nothing reaches the core unless the peripheral enable is set.
// - serial rx and tx flags are read-only and follow the serial unit.
// - all other implemented enable and flag bits except the pulse unit flags are read/write.
// - unimplemented bits read zero and ignore writes.
// - every implemented bit except the serial and pulse unit flags resets to zero on any reset.
// - peripheral enable passes enabled sources when set together with global enable, blocks all when clear.
// - pulse unit flags are read-only, cleared only inside each unit.
`timescale 1ns/1ps
module pibf_bank (
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          rst_n,
   // register port
   input  wire logic [pibf_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [pibf_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [pibf_pkg::DATA_W-1:0]   reg_rdata,
   // source event pulses
   input  wire logic                          t1_gate_acq_event,
   input  wire logic                          converter_done_event,
   input  wire logic                          t2_period_match_event,
   input  wire logic                          t1_overflow_event,
   input  wire logic                          comparator_two_event,
   input  wire logic                          comparator_one_event,
   // pending levels kept inside other units
   input  wire logic                          serial_rx_pending,
   input  wire logic                          serial_tx_pending,
   input  wire logic [3:0]                    pulse_unit_pending,
   // requests
   output logic                               periph_irq_request,
   output logic                               bank_irq
);
   import pibf_pkg::*;

   // a request register keeps the read-only bits where they belong
   function automatic logic [7:0] place_req1(input logic [7:0] rw, input logic rx,
                                             input logic tx);
      logic [7:0] v;
      v = rw & MASK_REQ1_WRITABLE;
      v[BIT_SERIAL_RX] = rx;
      v[BIT_SERIAL_TX] = tx;
      return v;
   endfunction : place_req1

   // storage
   logic [7:0] enable_first_reg;
   logic [7:0] enable_second_reg;
   logic [7:0] enable_third_reg;
   logic [7:0] core_control_reg;
   logic [7:0] reg_rdata_reg;
   logic [7:0] reg_rdata_next;
   logic       request_reg;
   logic       request_next;

   // decoded strobes
   wire logic wr_en1   = reg_wr && (reg_addr == OFS_ENABLE_FIRST);
   wire logic wr_en2   = reg_wr && (reg_addr == OFS_ENABLE_SECOND);
   wire logic wr_en3   = reg_wr && (reg_addr == OFS_ENABLE_THIRD);
   wire logic wr_req1  = reg_wr && (reg_addr == OFS_REQUEST_FIRST);
   wire logic wr_req2  = reg_wr && (reg_addr == OFS_REQUEST_SECOND);
   wire logic wr_core  = reg_wr && (reg_addr == OFS_CORE_CONTROL);
   wire logic wr_eclr  = reg_wr && (reg_addr == OFS_EVT_CLEAR);
   wire logic wr_een   = reg_wr && (reg_addr == OFS_EVT_ENABLE);

   // event pulses placed at their flag positions
   logic [7:0] req1_set;
   logic [7:0] req2_set;
   logic [7:0] req1_rw;
   logic [7:0] req2_q;
   always_comb begin
      req1_set = 8'h00;
      req1_set[BIT_T1_GATE_ACQ] = t1_gate_acq_event;
      req1_set[BIT_CONVERTER]   = converter_done_event;
      req1_set[BIT_T2_PERIOD]   = t2_period_match_event;
      req1_set[BIT_T1_OVERFLOW] = t1_overflow_event;
      req2_set = 8'h00;
      req2_set[BIT_COMPARATOR_TWO] = comparator_two_event;
      req2_set[BIT_COMPARATOR_ONE] = comparator_one_event;
   end

   // writable flags of the first request register
   pibf_flag_bits #(
      .MASK      (MASK_REQ1_WRITABLE)
   ) u_req1 (
      .clock     (clock),
      .rst_n     (rst_n),
      .set_pulse (req1_set),
      .wr_en     (wr_req1),
      .wr_data   (reg_wdata),
      .flags     (req1_rw)
   );

   // flags of the second request register
   pibf_flag_bits #(
      .MASK      (MASK_REQ2_WRITABLE)
   ) u_req2 (
      .clock     (clock),
      .rst_n     (rst_n),
      .set_pulse (req2_set),
      .wr_en     (wr_req2),
      .wr_data   (reg_wdata),
      .flags     (req2_q)
   );

   // assembled request views; serial and pulse bits are never stored here
   wire logic [7:0] req1_view = place_req1(req1_rw, serial_rx_pending,
                                           serial_tx_pending);
   wire logic [7:0] req3_view = {pulse_unit_pending, 4'h0};

   // per-register enabled-and-pending terms
   wire logic [7:0] hit1 = req1_view & enable_first_reg;
   wire logic [7:0] hit2 = req2_q    & enable_second_reg;
   wire logic [7:0] hit3 = req3_view & enable_third_reg;
   wire logic       any_hit    = |{hit1, hit2, hit3};
   wire logic       global_en  = core_control_reg[BIT_GLOBAL_EN];
   wire logic       periph_en  = core_control_reg[BIT_PERIPH_EN];

   // masked request: peripheral enable gates every source, global enable last
   assign request_next = any_hit && periph_en && global_en;

   // block events: any source set pulse, a rising core request
   wire logic [7:0] all_set_now = req1_set | req2_set;
   logic [7:0] evt_pulse;
   always_comb begin
      evt_pulse = 8'h00;
      evt_pulse[EVT_NEW_PENDING] = |all_set_now;
      evt_pulse[EVT_REQ_RISE]    = request_next && !request_reg;
   end

   logic [7:0] evt_status;
   logic [7:0] evt_enable;
   pibf_evt_status u_evt (
      .clock     (clock),
      .rst_n     (rst_n),
      .evt_pulse (evt_pulse),
      .clr_wr    (wr_eclr),
      .en_wr     (wr_een),
      .wr_data   (reg_wdata),
      .status    (evt_status),
      .enable    (evt_enable),
      .irq       (bank_irq)
   );

   // read multiplexer; unmapped and write-only offsets read zero
   always_comb begin
      unique case (reg_addr)
         OFS_ENABLE_FIRST:   reg_rdata_next = enable_first_reg;
         OFS_ENABLE_SECOND:  reg_rdata_next = enable_second_reg;
         OFS_ENABLE_THIRD:   reg_rdata_next = enable_third_reg;
         OFS_REQUEST_FIRST:  reg_rdata_next = req1_view;
         OFS_REQUEST_SECOND: reg_rdata_next = req2_q;
         OFS_REQUEST_THIRD:  reg_rdata_next = req3_view;
         OFS_CORE_CONTROL:   reg_rdata_next = core_control_reg;
         OFS_EVT_STATUS:     reg_rdata_next = evt_status;
         OFS_EVT_ENABLE:     reg_rdata_next = evt_enable;
         default:            reg_rdata_next = 8'h00;
      endcase
   end

   // enable registers: only implemented positions are stored
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         enable_first_reg  <= RESET_VALUE;
         enable_second_reg <= RESET_VALUE;
         enable_third_reg  <= RESET_VALUE;
         core_control_reg  <= RESET_VALUE;
      end else begin
         if (wr_en1)  enable_first_reg  <= reg_wdata & MASK_ENABLE_FIRST;
         if (wr_en2)  enable_second_reg <= reg_wdata & MASK_ENABLE_SECOND;
         if (wr_en3)  enable_third_reg  <= reg_wdata & MASK_ENABLE_THIRD;
         if (wr_core) core_control_reg  <= reg_wdata & MASK_CORE_CONTROL;
      end
   end

   // read data register and request flop
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata_reg <= RESET_VALUE;
         request_reg   <= 1'b0;
      end else begin
         reg_rdata_reg <= reg_rd ? reg_rdata_next : 8'h00;
         request_reg   <= request_next;
      end
   end

   assign reg_rdata          = reg_rdata_reg;
   assign periph_irq_request = request_reg;

   // checks
   a_event_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
      t1_overflow_event |=> req1_rw[BIT_T1_OVERFLOW])
      else $error("overflow event did not set its flag");
   a_set_beats_clear: assert property (@(posedge clock) disable iff (!rst_n)
      (comparator_one_event && wr_req2 && !reg_wdata[BIT_COMPARATOR_ONE])
      |=> req2_q[BIT_COMPARATOR_ONE])
      else $error("clearing write beat a comparator event");
   a_sw_clears_flag: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_req1 && !reg_wdata[BIT_CONVERTER] && !converter_done_event)
      |=> !req1_rw[BIT_CONVERTER])
      else $error("software write failed to clear converter flag");
   a_periph_blocks: assert property (@(posedge clock) disable iff (!rst_n)
      !$past(periph_en) |-> !periph_irq_request)
      else $error("request passed with peripheral enable clear");
   a_request_cause: assert property (@(posedge clock) disable iff (!rst_n)
      periph_irq_request |-> $past(any_hit) && $past(global_en))
      else $error("request without an enabled pending source");
   a_request_rises: assert property (@(posedge clock) disable iff (!rst_n)
      (global_en && periph_en && hit3[7] && !wr_core) |=> periph_irq_request)
      else $error("enabled pulse source did not raise request");
   a_serial_follows: assert property (@(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == OFS_REQUEST_FIRST)
      |=> reg_rdata[BIT_SERIAL_RX] == $past(serial_rx_pending))
      else $error("serial rx flag does not follow the unit");
   a_unused_zero: assert property (@(posedge clock) disable iff (!rst_n)
      $past(reg_rd && reg_addr == OFS_ENABLE_SECOND) |-> (reg_rdata & 8'h9F) == 8'h00)
      else $error("unimplemented bits read nonzero");
   a_reset_clears: assert property (@(posedge clock)
      !rst_n |=> (enable_first_reg == 8'h00) && (req1_rw == 8'h00) && !periph_irq_request)
      else $error("register not zero after reset");
   a_rdata_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside the answer cycle");

   // register layouts and unused positions
   a_enable1_layout: assert property (@(posedge clock) disable iff (!rst_n)
      wr_en1 |=> enable_first_reg == ($past(reg_wdata) & 8'hF3))
      else $error("first enable register layout broken");
   a_enable2_layout: assert property (@(posedge clock) disable iff (!rst_n)
      wr_en2 |=> enable_second_reg == ($past(reg_wdata) & 8'h60))
      else $error("second enable register layout broken");
   a_enable3_layout: assert property (@(posedge clock) disable iff (!rst_n)
      wr_en3 |=> enable_third_reg == ($past(reg_wdata) & 8'hF0))
      else $error("third enable register layout broken");
   a_req1_unused: assert property (@(posedge clock) disable iff (!rst_n)
      $past(reg_rd && reg_addr == OFS_REQUEST_FIRST) |-> (reg_rdata & 8'h0C) == 8'h00)
      else $error("first request unused bits read nonzero");
   a_req2_layout: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_req2 && !comparator_one_event && !comparator_two_event)
      |=> req2_q == ($past(reg_wdata) & 8'h60))
      else $error("second request register layout broken");
   a_core_unused: assert property (@(posedge clock) disable iff (!rst_n)
      $past(reg_rd && reg_addr == OFS_CORE_CONTROL) |-> (reg_rdata & 8'h3F) == 8'h00)
      else $error("core control unused bits read nonzero");
   a_pulse_readback: assert property (@(posedge clock) disable iff (!rst_n)
      $past(reg_rd && reg_addr == OFS_REQUEST_THIRD) |-> reg_rdata == {$past(pulse_unit_pending), 4'h0})
      else $error("pulse unit flags do not follow the units");

   // read-only levels and sticky flags
   a_serial_tx_follows: assert property (@(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == OFS_REQUEST_FIRST)
      |=> reg_rdata[BIT_SERIAL_TX] == $past(serial_tx_pending))
      else $error("serial tx flag does not follow the unit");
   a_gate_event_sets: assert property (@(posedge clock) disable iff (!rst_n)
      t1_gate_acq_event |=> req1_rw[BIT_T1_GATE_ACQ])
      else $error("gate event did not set its flag");
   a_converter_sets: assert property (@(posedge clock) disable iff (!rst_n)
      converter_done_event |=> req1_rw[BIT_CONVERTER])
      else $error("converter event did not set its flag");
   a_period_sets: assert property (@(posedge clock) disable iff (!rst_n)
      t2_period_match_event |=> req1_rw[BIT_T2_PERIOD])
      else $error("period match event did not set its flag");
   a_cmp_two_sets: assert property (@(posedge clock) disable iff (!rst_n)
      comparator_two_event |=> req2_q[BIT_COMPARATOR_TWO])
      else $error("comparator two event did not set its flag");
   a_flag_has_cause: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(req1_rw[BIT_T1_OVERFLOW]) |-> $past(t1_overflow_event) || $past(wr_req1))
      else $error("overflow flag set without a cause");
   a_flag_holds: assert property (@(posedge clock) disable iff (!rst_n)
      (req2_q[BIT_COMPARATOR_TWO] && !wr_req2) |=> req2_q[BIT_COMPARATOR_TWO])
      else $error("pending flag dropped without a write");

   // request path
   a_serial_request: assert property (@(posedge clock) disable iff (!rst_n)
      (serial_rx_pending && enable_first_reg[BIT_SERIAL_RX] && periph_en && global_en)
      |=> periph_irq_request)
      else $error("enabled serial flag did not raise request");

   // main scenarios
   c_request_seen: cover property (@(posedge clock) disable iff (!rst_n)
      $rose(periph_irq_request));
   c_set_and_clear: cover property (@(posedge clock) disable iff (!rst_n)
      comparator_two_event && wr_req2);
   c_bank_irq: cover property (@(posedge clock) disable iff (!rst_n)
      $rose(bank_irq));
   c_pulse_request: cover property (@(posedge clock) disable iff (!rst_n)
      (|hit3) && periph_irq_request);
   c_serial_both: cover property (@(posedge clock) disable iff (!rst_n)
      serial_rx_pending && serial_tx_pending);

endmodule : pibf_bank

// >>> logic/pibf_pkg.sv
/*
 * package of the peripheral interrupt enable and flag bank: register offsets,
 * implemented-bit masks, field positions, reset values and bus widths.
 * assumes a byte-wide register port with a four-bit address.
 */
package pibf_pkg;

   // bus geometry
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   // register offsets (byte index on the register port)
   localparam logic [3:0] OFS_ENABLE_FIRST   = 4'h0;
   localparam logic [3:0] OFS_ENABLE_SECOND  = 4'h1;
   localparam logic [3:0] OFS_ENABLE_THIRD   = 4'h2;
   localparam logic [3:0] OFS_REQUEST_FIRST  = 4'h3;
   localparam logic [3:0] OFS_REQUEST_SECOND = 4'h4;
   localparam logic [3:0] OFS_REQUEST_THIRD  = 4'h5;
   localparam logic [3:0] OFS_CORE_CONTROL   = 4'h6;
   localparam logic [3:0] OFS_EVT_STATUS     = 4'h7;
   localparam logic [3:0] OFS_EVT_CLEAR      = 4'h8;
   localparam logic [3:0] OFS_EVT_ENABLE     = 4'h9;

   // implemented bits of each register
   localparam logic [7:0] MASK_ENABLE_FIRST  = 8'hF3;
   localparam logic [7:0] MASK_ENABLE_SECOND = 8'h60;
   localparam logic [7:0] MASK_ENABLE_THIRD  = 8'hF0;
   localparam logic [7:0] MASK_REQ1_WRITABLE = 8'hC3;
   localparam logic [7:0] MASK_REQ1_SERIAL   = 8'h30;
   localparam logic [7:0] MASK_REQ2_WRITABLE = 8'h60;
   localparam logic [7:0] MASK_CORE_CONTROL  = 8'hC0;
   localparam logic [7:0] MASK_EVT           = 8'h03;

   // field positions, first request/enable register
   localparam int unsigned BIT_T1_GATE_ACQ  = 7;
   localparam int unsigned BIT_CONVERTER    = 6;
   localparam int unsigned BIT_SERIAL_RX    = 5;
   localparam int unsigned BIT_SERIAL_TX    = 4;
   localparam int unsigned BIT_T2_PERIOD    = 1;
   localparam int unsigned BIT_T1_OVERFLOW  = 0;
   // second register
   localparam int unsigned BIT_COMPARATOR_TWO = 6;
   localparam int unsigned BIT_COMPARATOR_ONE = 5;
   // third register: pulse units four..one in bits 7..4
   localparam int unsigned BIT_PULSE_LSB    = 4;
   // core control register
   localparam int unsigned BIT_GLOBAL_EN    = 7;
   localparam int unsigned BIT_PERIPH_EN    = 6;
   // block event status
   localparam int unsigned EVT_NEW_PENDING  = 0;
   localparam int unsigned EVT_REQ_RISE     = 1;

   // reset value of every register
   localparam logic [7:0] RESET_VALUE = 8'h00;

endpackage : pibf_pkg

// >>> logic/pibf_flag_bits.sv
/*
 * software-writable pending flags: hardware set pulses win over a software
 * write in the same cycle; bits outside the mask are never stored.
 * assumes set pulses synchronous to clock.
 */
`timescale 1ns/1ps
module pibf_flag_bits #(
   parameter logic [7:0] MASK = 8'hFF
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // hardware set pulses
   input  wire logic [7:0] set_pulse,
   // software write
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   // stored flags
   output logic      [7:0] flags
);
   import pibf_pkg::*;

   logic [7:0] flags_reg;
   logic [7:0] flags_next;

   // set wins over a same-cycle clearing write
   assign flags_next = (set_pulse | (wr_en ? wr_data : flags_reg)) & MASK;
   assign flags      = flags_reg;

   // flag storage
   always_ff @(posedge clock) begin
      if (!rst_n) flags_reg <= RESET_VALUE;
      else        flags_reg <= flags_next;
   end

endmodule : pibf_flag_bits

// >>> logic/pibf_evt_status.sv
/*
 * block event status: sticky bits, write-one-to-clear register, enable
 * register and a level interrupt output.
 * assumes event pulses and write strobes synchronous to clock.
 */
`timescale 1ns/1ps
module pibf_evt_status (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // events
   input  wire logic [7:0] evt_pulse,
   // software access
   input  wire logic       clr_wr,
   input  wire logic       en_wr,
   input  wire logic [7:0] wr_data,
   // state
   output logic      [7:0] status,
   output logic      [7:0] enable,
   output logic            irq
);
   import pibf_pkg::*;

   logic [7:0] status_reg;
   logic [7:0] status_next;
   logic [7:0] enable_reg;

   // an event in the clearing cycle keeps its bit set
   assign status_next = (evt_pulse | (status_reg & ~(clr_wr ? wr_data : 8'h00))) & MASK_EVT;
   assign status      = status_reg;
   assign enable      = enable_reg;
   assign irq         = |(status_reg & enable_reg);

   // status and enable storage
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         status_reg <= RESET_VALUE;
         enable_reg <= RESET_VALUE;
      end else begin
         status_reg <= status_next;
         if (en_wr) enable_reg <= wr_data & MASK_EVT;
      end
   end

endmodule : pibf_evt_status

// >>> testbench/pibf_periph_model.sv
/*
 * far-side model of the bank: timer, converter and comparator units that send
 * one-cycle set pulses, and serial and pulse units that hold their own pending
 * levels. assumes bench commands change just after a rising edge of clock.
 */
`timescale 1ns/1ps
module pibf_periph_model (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // bench commands
   input  wire logic [5:0] fire,
   input  wire logic [5:0] lvl_set,
   input  wire logic [5:0] lvl_clr,
   // towards the bank
   output logic      [5:0] event_pulse,
   output logic      [5:0] level
);
   // pulses last one cycle; a level falls only when its own unit clears it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         event_pulse <= 6'h00;
         level       <= 6'h00;
      end else begin
         event_pulse <= fire;
         level       <= (level | lvl_set) & ~lvl_clr;
      end
   end
endmodule : pibf_periph_model

// >>> testbench/pibf_bank_test.sv
/*
 * self-checking bench of the enable and flag bank: table of write/read rows,
 * then event, interrupt, request, read-only and reset cases.
 * assumes the bank's register port answers reads one cycle after the strobe.
 */
`timescale 1ns/1ps
module pibf_bank_test;
   import pibf_pkg::*;
   typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} pibf_row_t;
   logic       clock     = 1'b0;
   logic       rst_n     = 1'b0;
   logic [3:0] reg_addr  = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr    = 1'b0;
   logic       reg_rd    = 1'b0;
   logic [5:0] fire      = 6'h00;
   logic [5:0] lvl_set   = 6'h00;
   logic [5:0] lvl_clr   = 6'h00;
   logic [7:0] reg_rdata;
   logic [7:0] rv;
   logic [5:0] ev;
   logic [5:0] lv;
   logic       periph_irq_request;
   logic       bank_irq;
   int         n_errors  = 0;
   int         cmp_count = 0;
   // write, read-back rows: all ones or all zeros in, stored writable bits out
   pibf_row_t rows [15] = '{
      '{4'h0, 8'hFF, 8'hF3}, '{4'h1, 8'hFF, 8'h60}, '{4'h2, 8'hFF, 8'hF0},
      '{4'h3, 8'hFF, 8'hC3}, '{4'h4, 8'hFF, 8'h60}, '{4'h5, 8'hFF, 8'h00},
      '{4'h6, 8'hFF, 8'hC0}, '{4'hA, 8'hFF, 8'h00}, '{4'h8, 8'hFF, 8'h00},
      '{4'h0, 8'h00, 8'h00}, '{4'h3, 8'h00, 8'h00}, '{4'h4, 8'h00, 8'h00},
      '{4'h6, 8'h00, 8'h00}, '{4'h9, 8'hFF, 8'h03}, '{4'h9, 8'h00, 8'h00}};
   // event bit, register and flag it should set
   logic [3:0] ev_a [6] = '{4'h4, 4'h4, 4'h3, 4'h3, 4'h3, 4'h3};
   logic [7:0] ev_e [6] = '{8'h20, 8'h40, 8'h01, 8'h02, 8'h40, 8'h80};

   always #4 clock = ~clock;

   pibf_periph_model i_far (
      .clock(clock), .rst_n(rst_n), .fire(fire), .lvl_set(lvl_set),
      .lvl_clr(lvl_clr), .event_pulse(ev), .level(lv));

   pibf_bank i_dut (
      .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .t1_gate_acq_event(ev[5]), .converter_done_event(ev[4]),
      .t2_period_match_event(ev[3]), .t1_overflow_event(ev[2]),
      .comparator_two_event(ev[1]), .comparator_one_event(ev[0]),
      .serial_rx_pending(lv[1]), .serial_tx_pending(lv[0]),
      .pulse_unit_pending(lv[5:2]), .periph_irq_request(periph_irq_request),
      .bank_irq(bank_irq));

   task automatic tally_and_finish;
      if (n_errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick

   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask : wr

   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   // one-cycle command to the far side
   task automatic far(input logic [5:0] f, input logic [5:0] s, input logic [5:0] c);
      @(posedge clock);
      fire    <= f;
      lvl_set <= s;
      lvl_clr <= c;
      @(posedge clock);
      fire    <= 6'h00;
      lvl_set <= 6'h00;
      lvl_clr <= 6'h00;
      tick(2);
      #1;  // registered outputs of the last edge have settled
   endtask : far

   initial begin
      #200000;
      n_errors++;
      tally_and_finish();
   end

   initial begin
      tick(8);
      rst_n <= 1'b1;
      for (int a = 0; a < 16; a++) begin
         rd(a[3:0], rv);
         check("reset value", rv, RESET_VALUE);
      end
      tick(1);
      #1 check("read data idle", reg_rdata, 8'h00);
      for (int i = 0; i < 15; i++) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rv);
         check("row readback", rv, rows[i].e);
      end
      // every set pulse lands in its own flag with the first enable and core control clear
      for (int b = 0; b < 6; b++) begin
         far(6'h01 << b, 6'h00, 6'h00);
         rd(ev_a[b], rv);
         check("event flag", rv, ev_e[b]);
         wr(ev_a[b], 8'h00);
      end
      // event status, enable, clear and level interrupt
      wr(OFS_EVT_CLEAR, 8'h03);
      wr(OFS_EVT_ENABLE, 8'h01);
      far(6'h04, 6'h00, 6'h00);
      check("bank irq raised", bank_irq, 8'h01);
      wr(OFS_EVT_ENABLE, 8'h00);
      tick(1);
      check("bank irq masked", bank_irq, 8'h00);
      rd(OFS_EVT_STATUS, rv);
      check("event status", rv & 8'h01, 8'h01);
      wr(OFS_EVT_CLEAR, 8'h03);
      wr(OFS_EVT_ENABLE, 8'h01);
      tick(1);
      check("bank irq cleared", bank_irq, 8'h00);
      // request gated by peripheral and global enables; flag cleared before enabling
      wr(OFS_REQUEST_FIRST, 8'h00);
      wr(OFS_ENABLE_FIRST, 8'h01);
      tick(2);
      check("no request without enables", periph_irq_request, 8'h00);
      for (int k = 0; k < 4; k++) begin
         wr(OFS_CORE_CONTROL, {k[1], k[0], 6'h00});
         tick(2);
         check("request gating", periph_irq_request, 8'h00);
         far(6'h04, 6'h00, 6'h00);
         check("request on flag", periph_irq_request, {7'h00, k == 3});
         wr(OFS_REQUEST_FIRST, 8'h00);
         tick(2);
      end
      check("request after clear", periph_irq_request, 8'h00);
      rd(OFS_EVT_STATUS, rv);
      check("request rise event", rv, 8'h03);
      // all pulse unit levels: read-only flags, cleared only in the units
      far(6'h00, 6'h3C, 6'h00);
      wr(OFS_ENABLE_THIRD, 8'h40);
      wr(OFS_REQUEST_THIRD, 8'h00);
      rd(OFS_REQUEST_THIRD, rv);
      check("pulse flag", rv, 8'hF0);
      tick(1);
      check("pulse request", periph_irq_request, 8'h01);
      far(6'h00, 6'h00, 6'h3C);
      check("pulse request drop", periph_irq_request, 8'h00);
      // serial receive and transmit levels ignore register writes
      far(6'h00, 6'h03, 6'h00);
      wr(OFS_REQUEST_FIRST, 8'h00);
      rd(OFS_REQUEST_FIRST, rv);
      check("serial flag", rv, 8'h30);
      wr(OFS_ENABLE_FIRST, 8'h20);
      tick(2);
      check("serial request", periph_irq_request, 8'h01);
      far(6'h00, 6'h00, 6'h03);
      // set pulse beats a clearing write in the same cycle
      @(posedge clock);
      fire      <= 6'h04;
      @(posedge clock);
      fire      <= 6'h00;
      reg_wr    <= 1'b1;
      reg_addr  <= OFS_REQUEST_FIRST;
      reg_wdata <= 8'h00;
      @(posedge clock);
      reg_wr    <= 1'b0;
      rd(OFS_REQUEST_FIRST, rv);
      check("set over clear", rv, 8'h01);
      // reset in mid-run clears everything again
      @(posedge clock);
      rst_n <= 1'b0;
      tick(2);
      rst_n <= 1'b1;
      check("request after reset", periph_irq_request, 8'h00);
      for (int a = 0; a < 10; a++) begin
         rd(a[3:0], rv);
         check("second reset value", rv, RESET_VALUE);
      end
      tally_and_finish();
   end
endmodule : pibf_bank_test
